// [rtl/wwdr_top.sv]
/*
  window watchdog with primary-supply reset output and optional regulator
  shutdown. the supply reset is held low while the supply is bad, and a
  watchdog or pin fault holds it low for the reset delay plus a few clocks.
  in the shutdown build the regulators are also switched off for a while,
  and the reset delay only starts once the output regulates again.
  assumes the clock is the watchdog's own oscillator and all pin inputs are
  synchronous levels; the trigger is re-synchronised anyway. the timing
  capacitor is not measured: its effect comes in through FIRST_CYCLES, and
  the closed and open windows are build parameters as well.
*/
// Summary of operation
// - watchdog runs on its own independent clock
// - inactive while supply reset held low externally
// - fault holds reset low delay plus three
// - reset rise starts first timeout; expiry faults
// - first trigger starts closed and open windows
// - trigger inside closed window is a fault
// - no trigger before open end faults
// - trigger stuck high whole period faults
// - trigger high at reset rise starts windows
// - non-shutdown variant: reset only, regulators run
// - shutdown variant: regulators off, restart, delay
// - first timeout scales with timing capacitor; the code takes a fixed FIRST_CYCLES and never reads the capacitor
// - cap pin low, sync high: debug mode
// - leave debug once either condition lapses
// - cap pin low, sync low: report fault
`timescale 1ns/1ns
`default_nettype none
module wwdr_top
  import wwdr_pkg::*;
#(
  // timer lengths in watchdog clock cycles
  parameter int unsigned FIRST_CYCLES  = FT_CYCLES,
  parameter int unsigned CLS_CYCLES    = CLOSED_CYCLES,
  parameter int unsigned OPN_CYCLES    = OPEN_CYCLES,
  parameter int unsigned RST_DLY       = RESET_DELAY_CYCLES,
  parameter int unsigned OFF_DLY       = REG_OFF_CYCLES
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // supply supervision
  input  wire logic supply_ok,
  input  wire logic global_fault,
  // pins
  input  wire logic wd_trigger_in,
  input  wire logic wd_timing_cap_pin,
  input  wire logic sync_clock_in,
  // build option
  input  wire logic shutdown_variant,
  // outputs
  output var  logic primary_supply_reset_n,
  output var  logic regulators_enable,
  output var  logic debug_mode,
  output var  logic wd_fault
);

  typedef struct packed {
    wwdr_state_t      state;
    logic [1:0]       trig_sync;
    logic             trig_prev;
    logic [CNT_W-1:0] win_cnt;
    logic [CNT_W-1:0] cls_cnt;
    logic [CNT_W-1:0] high_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic             rst_out_n;
    logic             reg_en;
    logic             dbg;
    logic             fault;
  } wwdr_regs_t;

  // reset image: supply reset asserted, regulators allowed to run
  localparam wwdr_regs_t REGS_AT_RESET = '{
    state:     WWDR_IDLE,
    trig_sync: 2'h0,
    trig_prev: 1'b0,
    win_cnt:   '0,
    cls_cnt:   '0,
    high_cnt:  '0,
    hold_cnt:  '0,
    rst_out_n: 1'b0,
    reg_en:    1'b1,
    dbg:       1'b0,
    fault:     1'b0
  };

  wwdr_regs_t r;
  wwdr_regs_t next_r;

  // trigger view
  logic             trig;
  logic             trig_rise;
  // supervision and pin decode
  logic             ext_hold;
  logic             pin_fault;
  logic             armed;
  // timer end points
  logic             first_done;
  logic             cls_done;
  logic             open_done;
  logic             off_done;
  logic             hold_done;
  logic [CNT_W-1:0] period_len;
  logic             stuck;
  // fault decision
  logic             wd_event;
  logic             fault_now;

  // helpers read only the registered image, the pins and the supply supervision inputs
  assign trig       = r.trig_sync[1];
  assign trig_rise  = trig & ~r.trig_prev;
  // a bad supply or a global fault keeps the watchdog out of the picture
  assign ext_hold   = ~supply_ok | global_fault;
  assign pin_fault  = ~wd_timing_cap_pin & ~sync_clock_in;
  assign armed      = (r.state == WWDR_FIRST) ||
                      (r.state == WWDR_CLOSED) ||
                      (r.state == WWDR_OPEN);
  assign period_len = (r.state == WWDR_FIRST) ? CNT_W'(FIRST_CYCLES)
                                              : CNT_W'(OPN_CYCLES);
  assign first_done = (r.win_cnt + CNT_W'(1)) >= CNT_W'(FIRST_CYCLES);
  assign open_done  = (r.win_cnt + CNT_W'(1)) >= CNT_W'(OPN_CYCLES);
  assign cls_done   = (r.cls_cnt + CNT_W'(1)) >= CNT_W'(CLS_CYCLES);
  assign off_done   = (r.hold_cnt + CNT_W'(1)) >= CNT_W'(OFF_DLY);
  assign hold_done  = (r.hold_cnt + CNT_W'(1)) >= CNT_W'(RST_DLY + EXTRA_RESET_CYCLES);
  // the stuck count only runs in the first timeout and the open window
  assign stuck      = trig && ((r.high_cnt + CNT_W'(1)) >= period_len);

  // one pass builds the next register image
  always_comb begin
    next_r    = r;
    wd_event  = 1'b0;
    fault_now = 1'b0;

    next_r.trig_sync = {r.trig_sync[0], wd_trigger_in};
    next_r.trig_prev = trig;
    next_r.fault     = 1'b0;
    // debug follows the pins level-wise, so it ends as soon as a pin moves
    next_r.dbg       = ~wd_timing_cap_pin & sync_clock_in;

    // stuck-high tracking; any low cycle, or the closed window, restarts
    // it, so a slow but toggling trigger never counts as stuck
    if (trig && (r.state == WWDR_FIRST || r.state == WWDR_OPEN)) begin
      next_r.high_cnt = r.high_cnt + CNT_W'(1);
    end else begin
      next_r.high_cnt = '0;
    end

    // sequencer: IDLE waits for the supply reset to rise, FIRST runs the
    // long first-trigger timeout, CLOSED and OPEN police the window, and
    // REG_OFF, WAIT_REG and HOLD play out the fault response. a trigger
    // edge is only seen two clocks after the pin rises, so the windows
    // a controller sees are shifted by that much; they are not stretched.
    case (r.state)
      WWDR_IDLE: begin
        next_r.rst_out_n = ~ext_hold;
        next_r.win_cnt   = '0;
        next_r.cls_cnt   = '0;
        // supply reset is about to rise
        if (!ext_hold && !r.rst_out_n) begin
          // a trigger already high counts as the first pulse
          if (trig) begin
            next_r.state = WWDR_CLOSED;
          end else begin
            next_r.state = WWDR_FIRST;
          end
        end
      end

      WWDR_FIRST: begin
        // the stuck check shares the first-timeout length here
        next_r.win_cnt = r.win_cnt + CNT_W'(1);
        if (trig_rise) begin
          next_r.state   = WWDR_CLOSED;
          next_r.win_cnt = '0;
          next_r.cls_cnt = '0;
        end else if (first_done || stuck) begin
          wd_event = 1'b1;
        end
      end

      WWDR_CLOSED: begin
        // closed and open windows age together from the same edge
        next_r.win_cnt = r.win_cnt + CNT_W'(1);
        next_r.cls_cnt = r.cls_cnt + CNT_W'(1);
        // an edge here is early even if the closed window ends this cycle
        if (trig_rise) begin
          wd_event = 1'b1;
        end else if (open_done) begin
          wd_event = 1'b1;
        end else if (cls_done) begin
          next_r.state = WWDR_OPEN;
        end
      end

      WWDR_OPEN: begin
        next_r.win_cnt = r.win_cnt + CNT_W'(1);
        if (trig_rise) begin
          next_r.state   = WWDR_CLOSED;
          next_r.win_cnt = '0;
          next_r.cls_cnt = '0;
        end else if (open_done || stuck) begin
          wd_event = 1'b1;
        end
      end

      WWDR_REG_OFF: begin
        // regulators stay off for the whole enable delay
        next_r.hold_cnt = r.hold_cnt + CNT_W'(1);
        if (off_done) begin
          next_r.reg_en   = 1'b1;
          next_r.hold_cnt = '0;
          next_r.state    = WWDR_WAIT_REG;
        end
      end

      WWDR_WAIT_REG: begin
        // soft start is analog; wait for the output to regulate again.
        // a supply that never returns leaves the reset low, the safe side
        if (supply_ok) begin
          next_r.state    = WWDR_HOLD;
          next_r.hold_cnt = '0;
        end
      end

      WWDR_HOLD: begin
        next_r.hold_cnt = r.hold_cnt + CNT_W'(1);
        if (hold_done) begin
          next_r.state    = WWDR_IDLE;
          next_r.hold_cnt = '0;
        end
      end

      default: begin
        next_r.state = WWDR_IDLE;
      end
    endcase

    // the pin fault acts even while the watchdog is idle, but not in REG_OFF, WAIT_REG or HOLD
    fault_now = wd_event;
    if (pin_fault) begin
      if (r.state != WWDR_REG_OFF && r.state != WWDR_WAIT_REG && r.state != WWDR_HOLD) begin
        fault_now = 1'b1;
      end
    end

    if (fault_now && !r.dbg) begin
      next_r.fault     = 1'b1;
      next_r.rst_out_n = 1'b0;
      next_r.hold_cnt  = '0;
      next_r.win_cnt   = '0;
      next_r.cls_cnt   = '0;
      if (shutdown_variant) begin
        next_r.reg_en = 1'b0;
        next_r.state  = WWDR_REG_OFF;
      end else begin
        next_r.state  = WWDR_HOLD;
      end
    end else if (r.dbg && armed) begin
      // debug parks the watchdog with a fresh first timeout, so leaving
      // debug never finds a half-expired window
      next_r.win_cnt = '0;
      next_r.cls_cnt = '0;
      next_r.state   = WWDR_FIRST;
    end

    // external supervision takes precedence over the watchdog; a fault in
    // the same cycle must not leave the regulators switched off for good
    if (ext_hold && armed) begin
      next_r.state     = WWDR_IDLE;
      next_r.rst_out_n = 1'b0;
      next_r.reg_en    = 1'b1;
      next_r.fault     = 1'b0;
    end
  end

  // the asynchronous branch loads only the constant reset image
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= REGS_AT_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign primary_supply_reset_n = r.rst_out_n;
  assign regulators_enable      = r.reg_en;
  assign debug_mode             = r.dbg;
  assign wd_fault               = r.fault;

endmodule
`default_nettype wire

// [inc/wwdr_pkg.sv]
/*
  constants and state types for the window watchdog reset block.
  assumes a single 10 MHz watchdog clock; long times are top-level parameters.
*/
package wwdr_pkg;
  localparam int unsigned CLK_PERIOD_NS        = 100;
  // first-trigger timeout: 2.87 ms per pF plus 20 ms (typical)
  localparam int unsigned FT_SLOPE_NS_PER_PF   = 2870000;
  localparam int unsigned FT_OFFSET_MS         = 20;
  localparam int unsigned CAP_PF_DEFAULT       = 10;
  localparam int unsigned FT_TIME_NS           = FT_SLOPE_NS_PER_PF * CAP_PF_DEFAULT + FT_OFFSET_MS * 1000000;
  localparam int unsigned FT_CYCLES            = FT_TIME_NS / CLK_PERIOD_NS;
  // trigger period bounds are derived from timeout / 15 and timeout / 60
  localparam int unsigned PERIOD_MIN_DIV       = 15;
  localparam int unsigned PERIOD_MAX_DIV       = 60;
  localparam int unsigned CLOSED_CYCLES        = FT_CYCLES / (PERIOD_MIN_DIV * 2);
  localparam int unsigned OPEN_CYCLES          = FT_CYCLES / PERIOD_MAX_DIV * 4;
  localparam int unsigned EXTRA_RESET_CYCLES   = 3;
  localparam int unsigned RESET_DELAY_CYCLES   = 50000;
  localparam int unsigned REG_OFF_CYCLES       = 20000;
  localparam int unsigned CNT_W                = 24;

  typedef enum logic [2:0] {
    WWDR_IDLE,
    WWDR_FIRST,
    WWDR_CLOSED,
    WWDR_OPEN,
    WWDR_REG_OFF,
    WWDR_WAIT_REG,
    WWDR_HOLD
  } wwdr_state_t;
endpackage

// [verif/wwdr_monitor.sv]
/* checker on the watchdog top ports.
   assumes one clock; bound to every wwdr_top instance. */
`timescale 1ns/1ns
`default_nettype none
module wwdr_monitor #(parameter int unsigned RST_DLY = 30) (
  // clock and supply
  input wire logic clock,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic global_fault,
  // pins and build option
  input wire logic wd_timing_cap_pin,
  input wire logic sync_clock_in,
  input wire logic shutdown_variant,
  // outputs
  input wire logic primary_supply_reset_n,
  input wire logic regulators_enable,
  input wire logic debug_mode,
  input wire logic wd_fault
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  localparam int LOW_LAST = RST_DLY + 2;
  a_debug_entry: assert property (!wd_timing_cap_pin && sync_clock_in |=> debug_mode)
    else $error("debug mode not entered");
  a_debug_exit: assert property (wd_timing_cap_pin || !sync_clock_in |=> !debug_mode)
    else $error("debug mode not left");
  a_debug_quiet: assert property (debug_mode && $past(debug_mode) |-> !wd_fault)
    else $error("fault raised in debug mode");
  a_fault_pulse: assert property (wd_fault |=> !wd_fault)
    else $error("fault flag longer than one cycle");
  a_fault_hold: assert property (wd_fault && !shutdown_variant |-> !primary_supply_reset_n ##LOW_LAST
    !primary_supply_reset_n ##[1:3] primary_supply_reset_n) else $error("reset hold length wrong");
  a_regs_kept: assert property (!shutdown_variant |-> regulators_enable)
    else $error("regulators dropped in non-shutdown build");
  a_regs_off: assert property (wd_fault && shutdown_variant |-> ##[0:1] !regulators_enable)
    else $error("regulators not disabled on fault");
  a_supply_rst: assert property (!supply_ok || global_fault |=> !primary_supply_reset_n)
    else $error("reset high while supply bad");
  a_pin_fault: assert property (primary_supply_reset_n && !wd_timing_cap_pin && !sync_clock_in |-> ##[0:3] wd_fault)
    else $error("pin fault not reported");
endmodule
bind wwdr_top wwdr_monitor #(.RST_DLY(RST_DLY)) u_mon (
  .clock(clock), .rst_n(rst_n), .supply_ok(supply_ok), .global_fault(global_fault),
  .wd_timing_cap_pin(wd_timing_cap_pin), .sync_clock_in(sync_clock_in), .shutdown_variant(shutdown_variant),
  .primary_supply_reset_n(primary_supply_reset_n), .regulators_enable(regulators_enable),
  .debug_mode(debug_mode), .wd_fault(wd_fault));
`default_nettype wire

// [verif/wwdr_mcu.sv]
/* controller model: trigger pulses of 4 cycles every period cycles.
   period 0 means silent; stuck holds the trigger high, also in reset. */
`timescale 1ns/1ns
`default_nettype none
module wwdr_mcu (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] period,
  input  wire logic       stuck,
  output var  logic       trig
);
  logic [7:0] cnt;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      trig <= stuck;
    end else begin
      cnt <= (cnt + 8'h01 >= period) ? 8'h00 : cnt + 8'h01;
      trig <= stuck || (period != 8'h00 && cnt < 8'h04);
    end
  end
endmodule
`default_nettype wire

// [verif/window_watchdog_reset_test.sv]
/* self-checking bench for the window watchdog with a controller model.
   assumes short timer parameters so the run stays small. */
`timescale 1ns/1ns
`default_nettype none
module window_watchdog_reset_test;
  localparam int FIRST = 200;
  localparam int OPN = 60;
  localparam int OFF = 20;
  logic clock = 0, rst_n = 0, supply_ok = 1, global_fault = 0, cap = 1, sync = 0, variant = 0, stuck = 0;
  logic [7:0] period = 8'h00;
  wire logic trig, rst_o, reg_en, dbg, fault;
  int failures = 0, tests_run = 0, n;
  always #50 clock = ~clock;
  wwdr_top #(.FIRST_CYCLES(FIRST), .CLS_CYCLES(20), .OPN_CYCLES(OPN), .RST_DLY(30), .OFF_DLY(OFF)) DUT (
    .clock(clock), .rst_n(rst_n), .supply_ok(supply_ok), .global_fault(global_fault),
    .wd_trigger_in(trig), .wd_timing_cap_pin(cap), .sync_clock_in(sync), .shutdown_variant(variant),
    .primary_supply_reset_n(rst_o), .regulators_enable(reg_en), .debug_mode(dbg), .wd_fault(fault));
  wwdr_mcu mcu (.clock(clock), .rst_n(rst_n), .period(period), .stuck(stuck), .trig(trig));
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #10;
  endtask
  task automatic chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin failures++; $display("FAIL %0t level mismatch", $time); end
  endtask
  task automatic chk_n(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin failures++; $display("FAIL %0t fault at cycle %0d", $time, got); end
  endtask
  // counts cycles until a fault pulse, or lim if none comes
  task automatic wait_fault(input int lim);
    n = 0;
    while (n < lim && fault !== 1'b1) begin cyc(1); n++; end
  endtask
  task automatic restart(input logic v, input logic [7:0] p, input logic s);
    rst_n = 0; variant = v; period = p; stuck = s;
    cyc(8);
    rst_n = 1;
  endtask
  task automatic t_first; restart(0, 8'h00, 0); wait_fault(400); chk_n(n, FIRST - 2, FIRST + 8); endtask
  task automatic t_good; restart(0, 8'h28, 0); wait_fault(500); chk_n(n, 500, 500); endtask
  task automatic t_closed; restart(0, 8'h0a, 0); wait_fault(100); chk_n(n, 10, 30); endtask
  task automatic t_open; restart(0, 8'hfa, 0); wait_fault(150); chk_n(n, OPN - 2, OPN + 10); endtask
  task automatic t_stuck; restart(0, 8'h00, 1); wait_fault(150); chk_n(n, OPN - 2, OPN + 10); endtask
  task automatic t_debug;
    cap = 0; sync = 1; restart(0, 8'h00, 0);
    wait_fault(300); chk_n(n, 300, 300);
    chk(dbg, 1);
    cap = 1; cyc(2); chk(dbg, 0);
    wait_fault(300); chk_n(n, FIRST - 10, FIRST + 10);
    sync = 0;
  endtask
  task automatic t_pin;
    restart(0, 8'h28, 0); cyc(5);
    cap = 0; wait_fault(10); chk_n(n, 0, 4);
    cap = 1;
  endtask
  task automatic t_supply;
    supply_ok = 0; restart(0, 8'h00, 0);
    wait_fault(150); chk_n(n, 150, 150); chk(rst_o, 0);
    supply_ok = 1; global_fault = 1;
    wait_fault(150); chk_n(n, 150, 150); chk(rst_o, 0);
    global_fault = 0; wait_fault(400); chk_n(n, FIRST - 2, FIRST + 10);
  endtask
  task automatic t_shut;
    restart(1, 8'h00, 0); wait_fault(400); chk_n(n, FIRST - 2, FIRST + 8);
    cyc(1); chk(reg_en, 0);
    cyc(OFF + 5); chk(reg_en, 1); chk(rst_o, 0);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    t_first(); t_good(); t_closed(); t_open(); t_stuck();
    t_debug(); t_pin(); t_supply(); t_shut();
    final_report();
  end
  initial begin
    #1000000;
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
